// ### hw/srj_core.sv
// execution core for the stack, return, rotate, set-bit, short jump and subtract subset
`timescale 1ns/1ps
module srj_core
	import srj_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic INSTR_VALID,
	input wire srj_instr_t INSTR,
	output logic READY,
	output logic DONE,
	output logic INT_REENABLE,
	output logic [7:0] ACC,
	output srj_flags_t FLAGS,
	output logic [7:0] STACK_POINTER,
	output logic [15:0] PC,
	input wire logic MEM_WE,
	input wire logic [7:0] MEM_ADDR,
	input wire logic [7:0] MEM_WDATA,
	output logic [7:0] MEM_RDATA
);
	typedef enum logic {ST_IDLE, ST_SECOND} srj_state_t;

	srj_state_t state;
	srj_state_t next_state;
	srj_instr_t held;
	logic [7:0] mem [256];
	logic [7:0] next_acc;
	srj_flags_t next_flags;
	logic [7:0] next_stack_pointer;
	logic [15:0] next_pc;
	logic next_done;
	logic next_reenable;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic take;
	logic [7:0] bit_byte;
	logic [7:0] bit_mask;
	srj_alu_out_t alu_res;

	// ready is low on the first edge after reset, so nothing is taken while it reads low
	assign take = INSTR_VALID && READY;

	// low half of bit space maps to the bit area bytes, upper half to every eighth byte
	always_comb begin
		if (INSTR.operand[BIT_ADDR_SPACE_POS]) begin
			bit_byte = {INSTR.operand[7:3], 3'b000};
		end else begin
			bit_byte = {BIT_AREA_BASE_HIGH, INSTR.operand[6:3]};
		end
		bit_mask = 8'h01 << INSTR.operand[2:0];
	end

	srj_alu u_alu (
		.opcode(INSTR.opcode),
		.acc(ACC),
		.operand(INSTR.operand),
		.flags(FLAGS),
		.result(alu_res)
	);

	always_comb begin
		next_state = state;
		next_acc = ACC;
		next_flags = FLAGS;
		next_stack_pointer = STACK_POINTER;
		next_pc = PC;
		next_done = 1'b0;
		next_reenable = 1'b0;
		wr_en = 1'b0;
		wr_addr = MEM_ADDR;
		wr_data = MEM_WDATA;
		unique case (state)
			ST_IDLE: begin
				if (take) begin
					next_done = 1'b1;
					case (INSTR.opcode)
						OPC_BITWISE_OR_OP: begin
							wr_en = 1'b1;
							wr_addr = INSTR.operand;
							wr_data = mem[INSTR.operand] | ACC;
							next_pc = PC + PC_STEP_TWO_BYTE;
						end
						OPC_POP_OP: begin
							wr_en = 1'b1;
							wr_addr = INSTR.operand;
							wr_data = mem[STACK_POINTER];
							next_pc = PC + PC_STEP_TWO_BYTE;
							next_done = 1'b0;
							next_state = ST_SECOND;
						end
						OPC_PUSH_OP: begin
							next_stack_pointer = STACK_POINTER + STACK_STEP;
							next_pc = PC + PC_STEP_TWO_BYTE;
							next_done = 1'b0;
							next_state = ST_SECOND;
						end
						OPC_RETURN_OP, OPC_INTERRUPT_RETURN_OP: begin
							next_pc = {mem[STACK_POINTER], PC[7:0]};
							next_stack_pointer = STACK_POINTER - STACK_STEP;
							next_done = 1'b0;
							next_state = ST_SECOND;
						end
						OPC_ROTATE_LEFT_OP, OPC_ROTATE_LEFT_THROUGH_CARRY_OP,
						OPC_ROTATE_RIGHT_OP, OPC_ROTATE_RIGHT_THROUGH_CARRY_OP,
						OPC_SET_CARRY_OP: begin
							next_acc = alu_res.acc;
							next_flags = alu_res.flags;
							next_pc = PC + PC_STEP_ONE_BYTE;
						end
						OPC_SUBTRACT_WITH_BORROW_OP: begin
							next_acc = alu_res.acc;
							next_flags = alu_res.flags;
							next_pc = PC + PC_STEP_TWO_BYTE;
						end
						OPC_SET_BIT_OP: begin
							wr_en = 1'b1;
							wr_addr = bit_byte;
							wr_data = mem[bit_byte] | bit_mask;
							next_pc = PC + PC_STEP_TWO_BYTE;
						end
						OPC_SHORT_RELATIVE_JUMP_OP: begin
							next_pc = PC + PC_STEP_TWO_BYTE;
							next_done = 1'b0;
							next_state = ST_SECOND;
						end
						default: begin
							// codes outside this subset step over one byte so a stream never hangs
							next_pc = PC + PC_STEP_ONE_BYTE;
						end
					endcase
				end else if (MEM_WE) begin
					// loader writes only land in the idle state while no instruction is taken
					wr_en = 1'b1;
				end
			end
			ST_SECOND: begin
				next_done = 1'b1;
				next_state = ST_IDLE;
				case (held.opcode)
					OPC_POP_OP: begin
						next_stack_pointer = STACK_POINTER - STACK_STEP;
					end
					OPC_PUSH_OP: begin
						wr_en = 1'b1;
						wr_addr = STACK_POINTER;
						wr_data = mem[held.operand];
					end
					OPC_RETURN_OP, OPC_INTERRUPT_RETURN_OP: begin
						next_pc = {PC[15:8], mem[STACK_POINTER]};
						next_stack_pointer = STACK_POINTER - STACK_STEP;
						next_reenable = (held.opcode == OPC_INTERRUPT_RETURN_OP);
					end
					OPC_SHORT_RELATIVE_JUMP_OP: begin
						next_pc = PC + {{8{held.operand[SIGN_POS]}}, held.operand};
					end
					default: begin
						// only the two-cycle codes ever reach the second cycle
						next_done = 1'b1;
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= ST_IDLE;
			READY <= 1'b0;
		end else begin
			state <= next_state;
			READY <= (next_state == ST_IDLE);
		end
	end

	// the offered word may change once taken, so the second cycle works from this copy
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			held <= '0;
		end else if (take) begin
			held <= INSTR;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ACC <= RESET_ACC;
			FLAGS <= RESET_FLAGS;
			STACK_POINTER <= RESET_STACK_POINTER;
			PC <= RESET_PC;
		end else begin
			ACC <= next_acc;
			FLAGS <= next_flags;
			STACK_POINTER <= next_stack_pointer;
			PC <= next_pc;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			DONE <= 1'b0;
		end else begin
			DONE <= next_done;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			INT_REENABLE <= 1'b0;
		end else begin
			INT_REENABLE <= next_reenable;
		end
	end

	// data memory is left unreset: clearing 256 bytes would cost a wide reset tree
	always_ff @(posedge SYS_CLK) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		MEM_RDATA <= mem[MEM_ADDR];
	end
endmodule

// ### hw/srj_pkg.sv
// package: opcodes, reset values and carriers for the stack, rotate and jump execution block
// What this block does
// - opcode 42h ORs the accumulator into the direct byte, one cycle.
// - opcode D0h copies the byte at the stack pointer to direct, then decrements.
// - opcode C0h increments the stack pointer, then stores the direct byte there.
// - opcode 22h reloads the program counter from two stack bytes, two cycles.
// - opcode 32h returns like 22h and re-enables equal or lower priority interrupts.
// - returns pop high byte, decrement, pop low byte, decrement again.
// - opcode 23h rotates the accumulator left, bit 7 into bit 0.
// - opcode 33h rotates left through carry, bit 7 to carry, carry to bit 0.
// - opcode 03h rotates the accumulator right, bit 0 into bit 7.
// - opcode D3h sets the carry flag in one cycle.
// - opcode D2h sets one addressed bit, leaving its byte's other bits alone.
// - opcode 80h adds two to the program counter, then the offset, two cycles.
// - opcode 94h loads accumulator minus carry minus immediate byte, one cycle.
package srj_pkg;
	localparam logic [7:0] OPC_BITWISE_OR_OP = 8'h42;
	localparam logic [7:0] OPC_POP_OP = 8'hd0;
	localparam logic [7:0] OPC_PUSH_OP = 8'hc0;
	localparam logic [7:0] OPC_RETURN_OP = 8'h22;
	localparam logic [7:0] OPC_INTERRUPT_RETURN_OP = 8'h32;
	localparam logic [7:0] OPC_ROTATE_LEFT_OP = 8'h23;
	localparam logic [7:0] OPC_ROTATE_LEFT_THROUGH_CARRY_OP = 8'h33;
	localparam logic [7:0] OPC_ROTATE_RIGHT_OP = 8'h03;
	localparam logic [7:0] OPC_ROTATE_RIGHT_THROUGH_CARRY_OP = 8'h13;
	localparam logic [7:0] OPC_SET_CARRY_OP = 8'hd3;
	localparam logic [7:0] OPC_SET_BIT_OP = 8'hd2;
	localparam logic [7:0] OPC_SHORT_RELATIVE_JUMP_OP = 8'h80;
	localparam logic [7:0] OPC_SUBTRACT_WITH_BORROW_OP = 8'h94;

	localparam logic [7:0] RESET_ACC = 8'h00;
	localparam logic [7:0] RESET_STACK_POINTER = 8'h07;
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [15:0] PC_STEP_ONE_BYTE = 16'h0001;
	localparam logic [15:0] PC_STEP_TWO_BYTE = 16'h0002;
	localparam logic [7:0] STACK_STEP = 8'h01;
	localparam logic [3:0] BIT_AREA_BASE_HIGH = 4'h2;
	localparam int BIT_ADDR_SPACE_POS = 7;
	localparam int SIGN_POS = 7;
	localparam int NIBBLE_CARRY_POS = 4;
	localparam int BYTE_CARRY_POS = 8;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] operand;
	} srj_instr_t;

	typedef struct packed {
		logic carry;
		logic auxiliary_carry_flag;
		logic overflow_flag;
	} srj_flags_t;

	typedef struct packed {
		logic [7:0] acc;
		srj_flags_t flags;
	} srj_alu_out_t;

	localparam srj_flags_t RESET_FLAGS = '{carry: 1'b0, auxiliary_carry_flag: 1'b0,
		overflow_flag: 1'b0};
endpackage

// ### hw/srj_alu.sv
// combinational accumulator unit: rotates, set carry and subtract with borrow
`timescale 1ns/1ps
module srj_alu
	import srj_pkg::*;
(
	input wire logic [7:0] opcode,
	input wire logic [7:0] acc,
	input wire logic [7:0] operand,
	input wire srj_flags_t flags,
	output srj_alu_out_t result
);
	logic [8:0] diff_full;
	logic [4:0] diff_low;

	assign diff_full = {1'b0, acc} - {1'b0, operand} - {8'h00, flags.carry};
	assign diff_low = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, flags.carry};

	always_comb begin
		result.acc = acc;
		result.flags = flags;
		unique case (opcode)
			OPC_ROTATE_LEFT_OP: begin
				result.acc = {acc[6:0], acc[7]};
			end
			OPC_ROTATE_LEFT_THROUGH_CARRY_OP: begin
				result.acc = {acc[6:0], flags.carry};
				result.flags.carry = acc[7];
			end
			OPC_ROTATE_RIGHT_OP: begin
				result.acc = {acc[0], acc[7:1]};
			end
			OPC_ROTATE_RIGHT_THROUGH_CARRY_OP: begin
				result.acc = {flags.carry, acc[7:1]};
				result.flags.carry = acc[0];
			end
			OPC_SET_CARRY_OP: begin
				result.flags.carry = 1'b1;
			end
			OPC_SUBTRACT_WITH_BORROW_OP: begin
				result.acc = diff_full[7:0];
				result.flags.carry = diff_full[BYTE_CARRY_POS];
				result.flags.auxiliary_carry_flag = diff_low[NIBBLE_CARRY_POS];
				// overflow only when operands differ in sign and the result left the minuend's sign
				result.flags.overflow_flag = (acc[SIGN_POS] ^ operand[SIGN_POS])
					& (acc[SIGN_POS] ^ diff_full[SIGN_POS]);
			end
			default: begin
				result.acc = acc;
			end
		endcase
	end
endmodule

// ### sim/srj_core_chk.sv
// checker: timing and result properties of the execution core
`timescale 1ns/1ps
module srj_core_chk
	import srj_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic INSTR_VALID,
	input wire srj_instr_t INSTR,
	input wire logic READY,
	input wire logic DONE,
	input wire logic INT_REENABLE,
	input wire logic [7:0] ACC,
	input wire srj_flags_t FLAGS,
	input wire logic [7:0] STACK_POINTER,
	input wire logic [15:0] PC
);
	// one-cycle-old copies of the state, so results tie back to their cause
	logic [7:0] a, s, o;
	logic c;
	logic [15:0] p;
	wire tk = INSTR_VALID && READY;
	wire [7:0] op = INSTR.opcode;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	always_ff @(posedge SYS_CLK) begin
		a <= ACC;
		s <= STACK_POINTER;
		c <= FLAGS.carry;
		p <= PC;
		// operand kept from the taking edge, inputs may move afterwards
		if (tk)
			o <= INSTR.operand;
	end
	sequence busy_then_done;
		!READY && !DONE ##1 READY && DONE;
	endsequence
	sequence two_pops;
		STACK_POINTER == s - 8'h01 ##1 STACK_POINTER == s - 8'h01;
	endsequence
	sequence reenable_late;
		!INT_REENABLE ##1 INT_REENABLE;
	endsequence
	two_cycle_a: assert property (tk && op inside {8'hd0, 8'hc0, 8'h22, 8'h32, 8'h80}
		|=> busy_then_done) else $error("two-cycle op timing wrong");
	ret_pop_a: assert property (tk && op inside {8'h22, 8'h32} |=> two_pops)
		else $error("return stack pops wrong");
	late_reenable_a: assert property (tk && op == 8'h32 |=> reenable_late)
		else $error("interrupt re-enable missing");
	no_reen_a: assert property (tk && op == 8'h22 |=> ##1 !INT_REENABLE)
		else $error("plain return re-enabled interrupts");
	rot_left_a: assert property (tk && op == 8'h23 |=> DONE && ACC == {a[6:0], a[7]}
		&& PC == p + 16'h0001) else $error("rotate left wrong");
	carry_left_a: assert property (tk && op == 8'h33 |=> ACC == {a[6:0], c}
		&& FLAGS.carry == a[7]) else $error("rotate left through carry wrong");
	rot_right_a: assert property (tk && op == 8'h03 |=> ACC == {a[0], a[7:1]})
		else $error("rotate right wrong");
	carry_right_a: assert property (tk && op == 8'h13 |=> ACC == {c, a[7:1]}
		&& FLAGS.carry == a[0]) else $error("rotate right through carry wrong");
	set_carry_a: assert property (tk && op == 8'hd3 |=> DONE && FLAGS.carry)
		else $error("carry not set");
	jump_a: assert property (tk && op == 8'h80 |=> PC == p + 16'h0002
		##1 PC == p + {{8{o[7]}}, o}) else $error("short jump target wrong");
	sub_borrow_a: assert property (tk && op == 8'h94 |=> ACC == a - {7'h00, c} - o)
		else $error("subtract result wrong");
endmodule
bind srj_core srj_core_chk u_chk (.SYS_CLK, .RST_B, .INSTR_VALID, .INSTR, .READY, .DONE,
	.INT_REENABLE, .ACC, .FLAGS, .STACK_POINTER, .PC);

// ### sim/test_srj_core.sv
// self-checking bench for the execution core
`timescale 1ns/1ps
module test_srj_core import srj_pkg::*;;
	logic SYS_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic INSTR_VALID = 1'b0;
	logic MEM_WE = 1'b0;
	srj_instr_t INSTR = '0;
	logic [7:0] MEM_ADDR = 8'h00;
	logic [7:0] MEM_WDATA = 8'h00;
	logic READY, DONE, INT_REENABLE;
	logic [7:0] ACC, STACK_POINTER, MEM_RDATA;
	srj_flags_t FLAGS;
	logic [15:0] PC;
	logic [7:0] a = 8'h00;
	logic [7:0] s = 8'h07;
	logic [7:0] b;
	logic [15:0] p = 16'h0000;
	srj_flags_t f = '0;
	logic [8:0] r;
	logic [7:0] m [256];
	logic [35:0] q [$];
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;
	integer seed = 32'h1084;
	logic [7:0] ops [13] = '{8'h42, 8'hd0, 8'hc0, 8'h22, 8'h32, 8'h23, 8'h33, 8'h03,
		8'h13, 8'hd3, 8'hd2, 8'h80, 8'h94};
	always #12.5 SYS_CLK = ~SYS_CLK;
	srj_core u_dut (.SYS_CLK, .RST_B, .INSTR_VALID, .INSTR, .READY, .DONE, .INT_REENABLE,
		.ACC, .FLAGS, .STACK_POINTER, .PC, .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA);
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 10000) begin
			n_fail++;
			stop_test();
		end
	end
	// results retire on the done pulse; the oldest note is the one due
	always @(posedge SYS_CLK)
		if (DONE === 1'b1)
			chk({INT_REENABLE, ACC, FLAGS, STACK_POINTER, PC}, q.size() ? q.pop_front() : 'x);
	task wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge SYS_CLK);
		MEM_WE <= 1'b1;
		MEM_ADDR <= ad;
		MEM_WDATA <= d;
		@(posedge SYS_CLK);
		MEM_WE <= 1'b0;
		m[ad] = d;
	endtask
	task rd(input logic [7:0] ad);
		@(posedge SYS_CLK);
		MEM_ADDR <= ad;
		@(posedge SYS_CLK);
		@(negedge SYS_CLK);
		chk({28'h0, MEM_RDATA}, {28'h0, m[ad]});
	endtask
	task ex(input logic [7:0] op, input logic [7:0] d);
		int k;
		@(posedge SYS_CLK);
		INSTR_VALID <= 1'b1;
		INSTR <= {op, d};
		p = p + ((op inside {8'h42, 8'hd0, 8'hc0, 8'hd2, 8'h94, 8'h80}) ? 16'h0002 : 16'h0001);
		case (op)
		8'h42: m[d] = m[d] | a;
		8'hd0: begin
			m[d] = m[s];
			s = s - 8'h01;
		end
		8'hc0: begin
			s = s + 8'h01;
			m[s] = m[d];
		end
		8'h22, 8'h32: begin
			p = {m[s], m[s - 8'h01]};
			s = s - 8'h02;
		end
		8'h23: a = {a[6:0], a[7]};
		8'h33: {f.carry, a} = {a, f.carry};
		8'h03: a = {a[0], a[7:1]};
		8'h13: {a, f.carry} = {f.carry, a};
		8'hd3: f.carry = 1'b1;
		8'hd2: begin
			b = d[7] ? {d[7:3], 3'b000} : {4'h2, d[6:3]};
			m[b][d[2:0]] = 1'b1;
		end
		8'h80: p = p + {{8{d[7]}}, d};
		8'h94: begin
			r = {1'b0, a} - {8'h00, f.carry} - {1'b0, d};
			f.auxiliary_carry_flag = {1'b0, a[3:0]} < {1'b0, d[3:0]} + {4'h0, f.carry};
			f.overflow_flag = (a[7] ^ d[7]) & (a[7] ^ r[7]);
			f.carry = r[8];
			a = r[7:0];
		end
		default: ;
		endcase
		q.push_back({op == 8'h32, a, f, s, p});
		@(posedge SYS_CLK);
		INSTR_VALID <= 1'b0;
		k = 0;
		// bounded wait: a lost done pulse must not hang the run
		do @(negedge SYS_CLK); while (DONE !== 1'b1 && k++ < 8);
	endtask
	initial begin
		repeat (2) @(posedge SYS_CLK);
		RST_B <= 1'b1;
		@(negedge SYS_CLK);
		chk({INT_REENABLE, ACC, FLAGS, STACK_POINTER, PC}, {1'b0, 8'h00, 3'b000, 8'h07, 16'h0000});
		// memory is not cleared by reset, so every byte is loaded first
		for (int i = 0; i < 256; i++)
			wr(i[7:0], 8'($random(seed)));
		for (int i = 0; i < 300; i++)
			ex(ops[i < 13 ? i : int'($unsigned($random(seed)) % 13)], 8'($random(seed)));
		// a code outside the subset must only step the program counter and retire
		ex(8'ha5, 8'($random(seed)));
		for (int i = 0; i < 256; i++)
			rd(i[7:0]);
		stop_test();
	end
endmodule
